// >>> bms_pkg.sv
// Constants and types for the battery monitor sentence handler
package bms_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int CLEAR_WINDOW_S = 10;
   localparam int SEC_CYCLES = CLK_HZ / 1;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 8;
   localparam logic [2:0] CLEAR_X_COUNT = 3'h5;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_QMARK = 8'h3F;
   localparam logic [7:0] CH_X = 8'h78;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [23:0] ID_TIME = 24'h544431;
   localparam logic [23:0] ID_VER = 24'h565231;
   localparam logic [23:0] ID_INTCAL = 24'h544331;
   localparam logic [23:0] ID_EXTCAL = 24'h544332;
   localparam logic [23:0] ID_RESET = 24'h525331;
   localparam logic [5:0] TIME_LAST = 6'h22;
   localparam logic [5:0] VER_LAST = 6'h19;
   localparam logic [5:0] VER_BOOT_LAST = 6'h15;
   localparam logic [31:0] BOOT_TEXT = 32'h626F6F74;
   localparam logic [31:0] HW_TYPE_RST = 32'h48575831; // Arbitrary value
   localparam logic [63:0] FW_TEXT_RST = 64'h76312E30302E3030;
   localparam logic [2:0] FIELD_INTCAL = 3'h1;
   localparam logic [2:0] FIELD_EXTCAL = 3'h4;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_BODY = 3'b001,
      TX_SEP = 3'b010,
      TX_CKH = 3'b011,
      TX_CKL = 3'b100,
      TX_CR = 3'b101,
      TX_LF = 3'b110
   } bms_tx_state_t;
endpackage : bms_pkg

// >>> bms_sentence_handler.sv
// Sentence handler top with its output FIFO
`timescale 1ns/1ns
`default_nettype none

module bms_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("FIFO depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
   logic push, pop;

   always_comb begin
      in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
      out_valid = wr_reg != rd_reg;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_next = wr_reg + (AW+1)'(push);
      rd_next = rd_reg + (AW+1)'(pop);
      out_data = mem_reg[rd_reg[AW-1:0]];
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data;
      end
   end
endmodule : bms_byte_fifo

module bms_sentence_handler import bms_pkg::*; #(
   parameter int CYCLES_PER_SEC = SEC_CYCLES,
   parameter int DEPTH = FIFO_DEPTH,
   parameter logic [31:0] HW_TYPE = HW_TYPE_RST,
   parameter logic [63:0] FW_TEXT = FW_TEXT_RST
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_byte,
   input wire logic [15:0] time_year,
   input wire logic [7:0] time_month,
   input wire logic [7:0] time_day,
   input wire logic [7:0] time_hour,
   input wire logic [7:0] time_minute,
   input wire logic [7:0] time_second,
   input wire logic sleep_state,
   input wire logic [15:0] active_period_s,
   input wire logic [15:0] sleep_period_s,
   input wire logic [31:0] serial_number,
   input wire logic boot_mode,
   output logic int_cal_valid,
   output logic [7:0] int_cal_temp,
   output logic ext_cal_valid,
   output logic ext_cal_all,
   output logic [15:0] ext_cal_module,
   output logic [15:0] ext_cal_beta,
   output logic [15:0] ext_cal_gamma,
   output logic [15:0] ext_cal_delta,
   output logic clear_strobe,
   output logic [15:0] clear_count
);
   if (CYCLES_PER_SEC < 2) begin : g_chk
      $error("CYCLES_PER_SEC must be at least 2");
   end

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? CH_ZERO + 8'(n) : 8'h37 + 8'(n);
   endfunction : hex_char

   function automatic logic [3:0] hex_val(input logic [7:0] c);
      if (c >= 8'h61) begin
         return 4'(c - 8'h57);
      end else if (c >= 8'h41) begin
         return 4'(c - 8'h37);
      end
      return 4'(c - CH_ZERO);
   endfunction : hex_val

   function automatic logic [7:0] dec_char(input logic [15:0] v,
                                           input logic [1:0] p);
      logic [15:0] q;
      case (p)
         2'h0: q = v;
         2'h1: q = v / 16'd10;
         2'h2: q = v / 16'd100;
         default: q = v / 16'd1000;
      endcase
      return CH_ZERO + 8'(q % 16'd10);
   endfunction : dec_char

   // Seconds tick and uptime
   logic [31:0] tick_reg, tick_next, uptime_reg, uptime_next;
   logic sec_tick;
   always_comb begin
      sec_tick = tick_reg == 32'(CYCLES_PER_SEC - 1);
      tick_next = sec_tick ? '0 : tick_reg + 32'h1;
      uptime_next = uptime_reg + 32'(sec_tick);
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         tick_reg <= '0;
         uptime_reg <= '0;
      end else begin
         tick_reg <= tick_next;
         uptime_reg <= uptime_next;
      end
   end

   // Receive parser
   logic is_term, is_comma, dispatch;
   logic [23:0] id_reg, id_next;
   logic [2:0] fidx_reg, fidx_next;
   logic [31:0] acc_reg, acc_next;
   logic [31:0] fld_reg [1:4];
   logic [31:0] fld_next [1:4];
   logic qm_reg, qm_next;
   logic time_req, ver_req, reset_req;
   logic icv_next, ecv_next, ea_next;
   logic [7:0] ict_next;
   logic [15:0] em_next, eb_next, eg_next, ed_next;
   always_comb begin
      is_term = rx_byte == CH_CR || rx_byte == CH_LF;
      is_comma = rx_byte == CH_COMMA;
      id_next = id_reg;
      fidx_next = fidx_reg;
      acc_next = acc_reg;
      qm_next = qm_reg;
      fld_next = fld_reg;
      dispatch = 1'b0;
      if (rx_valid) begin
         if (is_comma || is_term) begin
            if (fidx_reg != 3'h0 && fidx_reg <= 3'h4) begin
               fld_next[fidx_reg] = acc_reg;
            end
            acc_next = '0;
            fidx_next = (fidx_reg == 3'h7) ? fidx_reg : fidx_reg + 3'h1;
            if (is_term) begin
               dispatch = fidx_reg != 3'h0;
               fidx_next = 3'h0;
               qm_next = 1'b0;
            end
         end else if (fidx_reg == 3'h0) begin
            id_next = {id_reg[15:0], rx_byte};
         end else begin
            acc_next = {acc_reg[27:0], hex_val(rx_byte)};
            if (fidx_reg == 3'h1 && rx_byte == CH_QMARK) begin
               qm_next = 1'b1;
            end
         end
      end
      time_req = dispatch && id_reg == ID_TIME && qm_reg;
      ver_req = dispatch && id_reg == ID_VER && qm_reg;
      reset_req = dispatch && id_reg == ID_RESET;
      icv_next = dispatch && id_reg == ID_INTCAL
                 && fidx_reg >= FIELD_INTCAL;
      ict_next = icv_next ? fld_next[1][7:0] : int_cal_temp;
      ecv_next = dispatch && id_reg == ID_EXTCAL
                 && fidx_reg >= FIELD_EXTCAL;
      ea_next = ecv_next ? fld_next[1] == 32'h0 : ext_cal_all;
      em_next = ecv_next ? fld_next[1][15:0] : ext_cal_module;
      eb_next = ecv_next ? fld_next[2][15:0] : ext_cal_beta;
      eg_next = ecv_next ? fld_next[3][15:0] : ext_cal_gamma;
      ed_next = ecv_next ? fld_next[4][15:0] : ext_cal_delta;
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         id_reg <= '0;
         fidx_reg <= '0;
         acc_reg <= '0;
         qm_reg <= 1'b0;
         fld_reg <= '{default: '0};
         int_cal_valid <= 1'b0;
         int_cal_temp <= '0;
         ext_cal_valid <= 1'b0;
         ext_cal_all <= 1'b0;
         ext_cal_module <= '0;
         ext_cal_beta <= '0;
         ext_cal_gamma <= '0;
         ext_cal_delta <= '0;
      end else begin
         id_reg <= id_next;
         fidx_reg <= fidx_next;
         acc_reg <= acc_next;
         qm_reg <= qm_next;
         fld_reg <= fld_next;
         int_cal_valid <= icv_next;
         int_cal_temp <= ict_next;
         ext_cal_valid <= ecv_next;
         ext_cal_all <= ea_next;
         ext_cal_module <= em_next;
         ext_cal_beta <= eb_next;
         ext_cal_gamma <= eg_next;
         ext_cal_delta <= ed_next;
      end
   end

   // Master clear window and sequence
   logic armed_reg, armed_next, clr_next;
   logic [2:0] xcnt_reg, xcnt_next;
   logic [3:0] win_reg, win_next;
   logic [15:0] cnt_next;
   always_comb begin
      armed_next = armed_reg;
      xcnt_next = xcnt_reg;
      win_next = win_reg;
      clr_next = 1'b0;
      if (sec_tick && win_reg != 4'(CLEAR_WINDOW_S)) begin
         win_next = win_reg + 4'h1;
      end
      if (win_reg == 4'(CLEAR_WINDOW_S)) begin
         armed_next = 1'b0;
      end
      if (rx_valid && armed_reg) begin
         if (rx_byte == CH_X && xcnt_reg < CLEAR_X_COUNT) begin
            xcnt_next = xcnt_reg + 3'h1;
         end else if (is_term && xcnt_reg == CLEAR_X_COUNT) begin
            clr_next = 1'b1;
            armed_next = 1'b0;
         end else if (!(is_term && xcnt_reg == 3'h0)) begin
            armed_next = 1'b0;
         end
      end
      if (reset_req) begin
         armed_next = 1'b1;
         xcnt_next = 3'h0;
         win_next = 4'h0;
      end
      cnt_next = clear_count + 16'(clr_next);
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         armed_reg <= 1'b1;
         xcnt_reg <= '0;
         win_reg <= '0;
         clear_strobe <= 1'b0;
         clear_count <= COUNT_RST;
      end else begin
         armed_reg <= armed_next;
         xcnt_reg <= xcnt_next;
         win_reg <= win_next;
         clear_strobe <= clr_next;
         clear_count <= cnt_next;
      end
   end

   // Sentence scheduling and generation
   bms_tx_state_t st_reg, st_next;
   logic time_pend_reg, time_pend_next, ver_pend_reg, ver_pend_next;
   logic kind_reg, kind_next;
   logic [15:0] per_reg, per_next, period;
   logic [5:0] idx_reg, idx_next;
   logic [7:0] ck_reg, ck_next, body_char, out_char;
   logic [15:0] yr_reg, yr_next;
   logic [7:0] tf_reg [5];
   logic [7:0] tf_next [5];
   logic [31:0] hx_reg, hx_next;
   logic boot_reg, boot_next, body_last, push, fifo_ready, per_hit;
   always_comb begin
      period = sleep_state ? sleep_period_s : active_period_s;
      per_next = per_reg;
      time_pend_next = time_pend_reg || time_req;
      per_hit = 1'b0;
      if (sec_tick) begin
         per_next = per_reg + 16'h1;
         if (period != 16'h0 && per_next >= period) begin
            per_next = 16'h0;
            per_hit = 1'b1;
            time_pend_next = 1'b1;
         end
      end
      ver_pend_next = ver_pend_reg || ver_req;
      body_char = CH_COMMA;
      case (idx_reg) inside
         [6'd0:6'd2]: body_char = kind_reg ? ID_VER[23-8*idx_reg -: 8]
                                           : ID_TIME[23-8*idx_reg -: 8];
         default: ;
      endcase
      if (!kind_reg) begin
         case (idx_reg) inside
            [6'd4:6'd7]: body_char = dec_char(yr_reg, 2'(6'd7 - idx_reg));
            6'd9, 6'd12, 6'd15, 6'd18, 6'd21:
               body_char = dec_char(16'(tf_reg[(idx_reg - 6'd9) / 3]),
                                    2'h1);
            6'd10, 6'd13, 6'd16, 6'd19, 6'd22:
               body_char = dec_char(16'(tf_reg[(idx_reg - 6'd10) / 3]),
                                    2'h0);
            6'd24, 6'd25: body_char = CH_ZERO;
            [6'd27:6'd34]:
               body_char = hex_char(hx_reg[4*(6'd34 - idx_reg) +: 4]);
            default: ;
         endcase
         body_last = idx_reg == TIME_LAST;
      end else begin
         case (idx_reg) inside
            [6'd4:6'd7]: body_char = HW_TYPE[8*(6'd7 - idx_reg) +: 8];
            [6'd9:6'd16]:
               body_char = hex_char(hx_reg[4*(6'd16 - idx_reg) +: 4]);
            [6'd18:6'd25]:
               body_char = boot_reg ? BOOT_TEXT[8*(6'd21 - idx_reg) +: 8]
                                    : FW_TEXT[8*(6'd25 - idx_reg) +: 8];
            default: ;
         endcase
         body_last = idx_reg == (boot_reg ? VER_BOOT_LAST : VER_LAST);
      end
      case (st_reg)
         TX_BODY: out_char = body_char;
         TX_SEP: out_char = CH_COMMA;
         TX_CKH: out_char = hex_char(ck_reg[7:4]);
         TX_CKL: out_char = hex_char(ck_reg[3:0]);
         TX_CR: out_char = CH_CR;
         default: out_char = CH_LF;
      endcase
      push = st_reg != TX_IDLE;
      st_next = st_reg;
      idx_next = idx_reg;
      ck_next = ck_reg;
      kind_next = kind_reg;
      yr_next = yr_reg;
      tf_next = tf_reg;
      hx_next = hx_reg;
      boot_next = boot_reg;
      if (st_reg == TX_IDLE) begin
         idx_next = '0;
         ck_next = '0;
         boot_next = boot_mode;
         yr_next = time_year;
         tf_next = '{time_month, time_day, time_hour, time_minute,
                     time_second};
         if (ver_pend_reg) begin
            kind_next = 1'b1;
            hx_next = serial_number;
            ver_pend_next = ver_req;
            st_next = TX_BODY;
         end else if (time_pend_reg) begin
            kind_next = 1'b0;
            hx_next = uptime_reg;
            time_pend_next = time_req || per_hit;
            st_next = TX_BODY;
         end
      end else if (fifo_ready) begin
         if (st_reg == TX_BODY || st_reg == TX_SEP) begin
            ck_next = ck_reg + out_char;
         end
         case (st_reg)
            TX_BODY: begin
               idx_next = idx_reg + 6'h1;
               if (body_last) begin
                  st_next = TX_SEP;
               end
            end
            TX_SEP: st_next = TX_CKH;
            TX_CKH: st_next = TX_CKL;
            TX_CKL: st_next = TX_CR;
            TX_CR: st_next = TX_LF;
            default: st_next = TX_IDLE;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= TX_IDLE;
         time_pend_reg <= 1'b0;
         ver_pend_reg <= 1'b1;
         kind_reg <= 1'b0;
         per_reg <= '0;
         idx_reg <= '0;
         ck_reg <= '0;
         yr_reg <= '0;
         tf_reg <= '{default: '0};
         hx_reg <= '0;
         boot_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         time_pend_reg <= time_pend_next;
         ver_pend_reg <= ver_pend_next;
         kind_reg <= kind_next;
         per_reg <= per_next;
         idx_reg <= idx_next;
         ck_reg <= ck_next;
         yr_reg <= yr_next;
         tf_reg <= tf_next;
         hx_reg <= hx_next;
         boot_reg <= boot_next;
      end
   end

   bms_byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) bms_byte_fifo_inst (
      .clock(clock),
      .rst(rst),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(out_char),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_byte)
   );
endmodule : bms_sentence_handler

`default_nettype wire

// >>> bms_handler_asserts.sv
// Port checker for the sentence handler
`timescale 1ns/1ns
`default_nettype none
module bms_handler_asserts import bms_pkg::*; #(
   parameter int CYCLES_PER_SEC = 20
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_byte,
   input wire logic int_cal_valid,
   input wire logic ext_cal_valid,
   input wire logic ext_cal_all,
   input wire logic [15:0] ext_cal_module,
   input wire logic clear_strobe,
   input wire logic [15:0] clear_count
);
   localparam int WIN_MAX = CLEAR_WINDOW_S * CYCLES_PER_SEC + 8;
   logic [15:0] arm_reg;
   logic [7:0] prev_reg;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Cycles since reset or since a line not ending in x
   always_ff @(posedge clock) begin
      if (rst) begin
         arm_reg <= 16'h0000;
         prev_reg <= 8'h00;
      end else begin
         if (rx_valid) begin
            prev_reg <= rx_byte;
         end
         if (rx_valid && (rx_byte == CH_CR || rx_byte == CH_LF)
             && prev_reg != CH_X) begin
            arm_reg <= 16'h0000;
         end else if (arm_reg != 16'hFFFF) begin
            arm_reg <= arm_reg + 16'h0001;
         end
      end
   end
   sequence s_term_seen;
      $past(rx_valid) && ($past(rx_byte) == CH_CR || $past(rx_byte) == CH_LF);
   endsequence
   sequence s_ver_head;
      tx_valid && tx_byte == 8'h56;
   endsequence
   property p_tx_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
   endproperty
   property p_ver_boot;
      $fell(rst) |-> ##[1:4] s_ver_head;
   endproperty
   property p_int_cause;
      int_cal_valid |-> s_term_seen;
   endproperty
   property p_ext_cause;
      ext_cal_valid |-> s_term_seen;
   endproperty
   property p_int_pulse;
      int_cal_valid |=> !int_cal_valid;
   endproperty
   property p_ext_all;
      ext_cal_valid |-> ext_cal_all == (ext_cal_module == 16'h0000);
   endproperty
   property p_clr_cause;
      clear_strobe |-> s_term_seen;
   endproperty
   property p_clr_count;
      clear_strobe |-> clear_count == $past(clear_count) + 16'h0001;
   endproperty
   property p_cnt_hold;
      !clear_strobe |-> $stable(clear_count);
   endproperty
   property p_clr_window;
      clear_strobe |-> arm_reg <= WIN_MAX;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx moved");
   a_ver_boot: assert property (p_ver_boot) else $error("no ver");
   a_int_cause: assert property (p_int_cause) else $error("int cal");
   a_ext_cause: assert property (p_ext_cause) else $error("ext cal");
   a_int_pulse: assert property (p_int_pulse) else $error("long");
   a_ext_all: assert property (p_ext_all) else $error("broadcast");
   a_clr_cause: assert property (p_clr_cause) else $error("clear");
   a_clr_count: assert property (p_clr_count) else $error("count");
   a_cnt_hold: assert property (p_cnt_hold) else $error("drift");
   a_clr_window: assert property (p_clr_window) else $error("late");
endmodule : bms_handler_asserts
bind bms_sentence_handler bms_handler_asserts #(
   .CYCLES_PER_SEC(CYCLES_PER_SEC)
) bms_handler_asserts_inst (.clock(clock), .rst(rst), .rx_valid(rx_valid),
   .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_byte(tx_byte), .int_cal_valid(int_cal_valid),
   .ext_cal_valid(ext_cal_valid), .ext_cal_all(ext_cal_all),
   .ext_cal_module(ext_cal_module), .clear_strobe(clear_strobe),
   .clear_count(clear_count));
`default_nettype wire

// >>> bms_host_model.sv
// Host model: sends sentences, takes the unit's bytes
`timescale 1ns/1ns
`default_nettype none
module bms_host_model import bms_pkg::*; (
   input wire logic clock,
   input wire logic slow,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_byte
);
   logic [7:0] got[$];
   logic [1:0] phase = 2'h0;
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end
   // Takes bytes; ready one cycle in four when slow
   always @(posedge clock) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         got.push_back(tx_byte);
      end
      phase <= phase + 2'h1;
      tx_ready <= !slow || phase == 2'h3;
   end
   // Whole lines, hex fields, temperature byte taken as sent
   // One calibration, known coefficients only
   // Clear bytes are the first sent after startup
   task automatic send_line(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clock);
         rx_valid <= 1'b1;
         rx_byte <= s[i];
      end
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask : send_line
endmodule : bms_host_model
`default_nettype wire

// >>> bms_sentence_handler_bench.sv
// Self-checking bench for the sentence handler
`timescale 1ns/1ns
`default_nettype none
module bms_sentence_handler_bench import bms_pkg::*;;
   localparam int CPS = 20;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   logic rx_valid, tx_valid, tx_ready, int_cal_valid, ext_cal_valid;
   logic ext_cal_all, clear_strobe;
   logic [7:0] rx_byte, tx_byte, int_cal_temp;
   logic [15:0] ext_cal_module, ext_cal_beta, ext_cal_gamma, ext_cal_delta;
   logic [15:0] clear_count;
   logic [15:0] time_year = 16'h07DE;
   logic [7:0] time_month = 8'h0A;
   logic [7:0] time_day = 8'h07;
   logic [7:0] time_hour = 8'h00;
   logic [7:0] time_minute = 8'h32;
   logic [7:0] time_second = 8'h3B;
   logic sleep_state = 1'b0;
   logic [15:0] active_period_s = 16'h0000;
   logic [15:0] sleep_period_s = 16'h0000;
   logic [31:0] serial_number = 32'h00A1B2C3;
   logic boot_mode = 1'b0;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] ln[$];
   logic [7:0] ex[$];
   always #4 clock = ~clock;
   always @(posedge clock) cyc <= rst ? 0 : cyc + 1;
   bms_sentence_handler #(.CYCLES_PER_SEC(CPS)) bms_sentence_handler_inst (
      .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
      .time_year(time_year), .time_month(time_month), .time_day(time_day),
      .time_hour(time_hour), .time_minute(time_minute),
      .time_second(time_second), .sleep_state(sleep_state),
      .active_period_s(active_period_s), .sleep_period_s(sleep_period_s),
      .serial_number(serial_number), .boot_mode(boot_mode),
      .int_cal_valid(int_cal_valid), .int_cal_temp(int_cal_temp),
      .ext_cal_valid(ext_cal_valid), .ext_cal_all(ext_cal_all),
      .ext_cal_module(ext_cal_module), .ext_cal_beta(ext_cal_beta),
      .ext_cal_gamma(ext_cal_gamma), .ext_cal_delta(ext_cal_delta),
      .clear_strobe(clear_strobe), .clear_count(clear_count));
   bms_host_model bms_host_model_inst (.clock(clock), .slow(slow),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_byte(tx_byte));
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : chk
   function automatic logic [7:0] hexc(input logic [3:0] v);
      return (v > 4'h9) ? 8'h37 + 8'(v) : 8'h30 + 8'(v);
   endfunction : hexc
   // Pops one whole line from the host model
   task automatic get_line();
      logic done;
      done = 1'b0;
      ln.delete();
      for (int n = 0; n < 3000 && !done; n++) begin
         @(posedge clock);
         #1;
         while (bms_host_model_inst.got.size() > 0 && !done) begin
            ln.push_back(bms_host_model_inst.got.pop_front());
            done = (ln[ln.size() - 1] == CH_LF);
         end
      end
      if (!done) begin
         err_total++;
         final_report();
      end
   endtask : get_line
   task automatic push_str(input string s);
      for (int i = 0; i < s.len(); i++) ex.push_back(s[i]);
   endtask : push_str
   // Adds sum checksum and CR LF, then compares the line
   task automatic verify();
      logic [7:0] sum;
      sum = 8'h00;
      foreach (ex[i]) sum += ex[i];
      ex.push_back(hexc(sum[7:4]));
      ex.push_back(hexc(sum[3:0]));
      ex.push_back(CH_CR);
      ex.push_back(CH_LF);
      chk(ln.size(), ex.size());
      foreach (ex[i]) if (i < ln.size()) chk(ln[i], ex[i]);
      ex.delete();
   endtask : verify
   task automatic watch(output logic [2:0] seen);
      seen = 3'h0;
      repeat (6) begin
         #1;
         seen |= {clear_strobe, ext_cal_valid, int_cal_valid};
         @(posedge clock);
      end
   endtask : watch
   task automatic test_clear_early();
      logic [2:0] seen;
      bms_host_model_inst.send_line("xxxxx\015");
      watch(seen);
      chk(seen, 3'h4);
      chk(clear_count, 16'h0001);
      get_line();
      push_str($sformatf("%s,HWX1,00A1B2C3,v1.00.00,", ID_VER));
      verify();
      $display("test clear_early done");
   endtask : test_clear_early
   task automatic test_clear_late();
      logic [2:0] seen;
      bms_host_model_inst.send_line($sformatf("%s,00\n", ID_RESET));
      repeat (CLEAR_WINDOW_S * CPS + 30) @(posedge clock);
      bms_host_model_inst.send_line("xxxxx\n");
      watch(seen);
      chk(seen, 3'h0);
      chk(clear_count, 16'h0001);
      bms_host_model_inst.send_line($sformatf("%s,00\n", ID_RESET));
      bms_host_model_inst.send_line("xxxxx\n");
      watch(seen);
      chk(seen, 3'h4);
      chk(clear_count, 16'h0002);
      $display("test clear_late done");
   endtask : test_clear_late
   task automatic test_ver_req();
      @(posedge clock);
      boot_mode <= 1'b1;
      bms_host_model_inst.send_line($sformatf("%s,?\015\n", ID_VER));
      get_line();
      push_str($sformatf("%s,HWX1,00A1B2C3,boot,", ID_VER));
      verify();
      boot_mode <= 1'b0;
      $display("test ver_req done");
   endtask : test_ver_req
   task automatic test_time_req();
      int t0;
      logic [31:0] up;
      @(posedge clock);
      slow <= 1'b1;
      t0 = cyc / CPS;
      bms_host_model_inst.send_line($sformatf("%s,?,1A\n", ID_TIME));
      get_line();
      up = 32'h0;
      push_str($sformatf("%s,2014,10,07,00,50,59,00,", ID_TIME));
      for (int i = 27; i < 35 && i < ln.size(); i++) begin
         ex.push_back(ln[i]);
         up = {up[27:0], ln[i] > 8'h39 ? ln[i][3:0] + 4'h9 : ln[i][3:0]};
      end
      chk(up >= t0 && up <= cyc / CPS, 1);
      push_str(",");
      verify();
      slow <= 1'b0;
      $display("test time_req done");
   endtask : test_time_req
   task automatic do_ext(input string s, input logic [63:0] want);
      logic [2:0] seen;
      bms_host_model_inst.send_line(s);
      watch(seen);
      chk(seen, 3'h2);
      chk(ext_cal_all, want[63:48] == 16'h0000);
      chk({ext_cal_module, ext_cal_beta}, want[63:32]);
      chk({ext_cal_gamma, ext_cal_delta}, want[31:0]);
   endtask : do_ext
   task automatic test_cal();
      logic [2:0] seen;
      bms_host_model_inst.send_line($sformatf("%s,78,B0\n", ID_INTCAL));
      watch(seen);
      chk(seen, 3'h1);
      chk(int_cal_temp, 8'h78);
      do_ext($sformatf("%s,0000,12,34,56,7B\n", ID_EXTCAL),
             64'h0000_0012_0034_0056);
      do_ext($sformatf("%s,5,ABCD,1,FFFF,00\n", ID_EXTCAL),
             64'h0005_ABCD_0001_FFFF);
      $display("test cal done");
   endtask : test_cal
   task automatic count_lines(input int cycles, output int n);
      repeat (60) @(posedge clock);
      bms_host_model_inst.got.delete();
      repeat (cycles) @(posedge clock);
      n = 0;
      foreach (bms_host_model_inst.got[i]) begin
         n += bms_host_model_inst.got[i] == 8'h54;
      end
   endtask : count_lines
   task automatic test_period();
      int n;
      @(posedge clock);
      active_period_s <= 16'h0004;
      sleep_period_s <= 16'h0002;
      count_lines(400, n);
      chk(n >= 4 && n <= 6, 1);
      sleep_state <= 1'b1;
      count_lines(400, n);
      chk(n >= 7 && n <= 11, 1);
      sleep_period_s <= 16'h0000;
      count_lines(300, n);
      chk(n, 0);
      $display("test period done");
   endtask : test_period
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      test_clear_early();
      test_clear_late();
      test_ver_req();
      test_time_req();
      test_cal();
      test_period();
      final_report();
   end
endmodule : bms_sentence_handler_bench
`default_nettype wire
